// file: rtl/mode_seq_pkg.sv
package mode_seq_pkg;
    localparam int CLK_HZ = 125000000;
    localparam int RESET_DELAY_US = 10;
    localparam int RESET_DELAY_CYC = (RESET_DELAY_US * (CLK_HZ / 1000000) < 1) ? 1 : RESET_DELAY_US * (CLK_HZ / 1000000);
    localparam int LONG_WINDOW_MS = 200;
    localparam int LONG_WINDOW_CYC = LONG_WINDOW_MS * (CLK_HZ / 1000);
    localparam int CNT_W = 32;
    localparam int SPI_W = 16;
    localparam int WD_RESET_LIMIT = 3;
    localparam logic [2:0] MODE_NORMAL = 3'h0;
    localparam logic [2:0] MODE_SLEEP = 3'h1;
    localparam logic [2:0] MODE_STOP = 3'h2;
    localparam logic [2:0] MODE_SOFT_RESET = 3'h3;
    localparam int CMD_MODE_POS = 0;
    localparam logic [1:0] CMD_MODE = 2'h0;
    localparam logic [1:0] CMD_ALLOWED = 2'h1;
    localparam logic [1:0] CMD_OTHER = 2'h2;
    typedef enum logic [5:0] {
        ST_INIT = 6'h01,
        ST_NORMAL = 6'h02,
        ST_STOP = 6'h04,
        ST_SLEEP = 6'h08,
        ST_RESTART = 6'h10,
        ST_FAILSAFE = 6'h20
    } mode_e;
endpackage

// file: rtl/mode_seq_if.sv
interface mode_seq_if;
    logic start;
    logic [31:0] load;
    logic run;
    logic done;
    modport owner(output start, output load, output run, input done);
    modport timer(input start, input load, input run, output done);
endinterface

// file: rtl/seq_timer.sv
module seq_timer
    import mode_seq_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    mode_seq_if.timer t
);
    logic [CNT_W-1:0] cnt_q, cnt_d;
    logic done_q, done_d;
    always_comb begin
        cnt_d = cnt_q;
        done_d = 1'b0;
        if (t.start) begin
            cnt_d = t.load;
        end else if (t.run && cnt_q != '0) begin
            cnt_d = cnt_q - 32'h1;
            done_d = (cnt_q == 32'h1);
        end
    end
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cnt_q <= '0;
            done_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            done_q <= done_d;
        end
    end
    assign t.done = done_q;
endmodule // seq_timer

// file: rtl/mode_sequencer.sv
// How it works
// RL1: Power-up and soft reset enter init; six modes are provided.
// RL2: Stop keeps the main regulator on; sleep turns it off.
// RL3: Restart follows wakes or failures, then normal after the reset delay.
// RL4: Critical faults enter fail-safe, regulator off, left on wake without overtemperature; the code ignores critical faults during init.
// RL5: Development mode halts the watchdog but keeps all modes reachable.
// RL6: All configuration travels as 16-bit SPI words; the code takes SECOND_MISS_SELECT and MAX_RESET_LIMIT as input pins.
// RL7: Host writes the mode field; restart clears it.
// RL8: During init the strap pin is an input with pull-up and is sampled.
// RL9: Strap low selects development mode; host sends one arbitrary command.
// RL10: Strap high and state bit 1: first missed trigger causes restart and fail outputs.
// RL11: Strap high and state bit 0: second missed trigger causes restart.
// RL12: Software picks the miss count through a hardware control bit.
// RL13: Init starts after power-on threshold or soft reset command.
// RL14: After the supply threshold wait the reset delay, release reset, open long window.
// RL15: Any SPI command in init moves to normal.
// RL16: No trigger in the long window records failure, restart, one reset; the code ends the window only on an SPI command, a trigger does not stop it.
// RL17: With the limit bit, stop resets after three consecutive watchdog resets.
// RL18: Wake events during init are ignored and not retained.
// RL19: Host should trigger and configure the watchdog first.
// RL20: No undervoltage flag or fail output below threshold; reset held low.
// RL21: Stop mode refuses most writes and flags an SPI failure.
// RL22: Stop to sleep request flags SPI failure and enters restart.
// RL23: Delays are counted in clock cycles with shortenable parameters.
// RL24: Consecutive reset counter clears at power-on and on good triggers.
module mode_sequencer
    import mode_seq_pkg::*;
#(
    parameter int RESET_DELAY = RESET_DELAY_CYC,
    parameter int LONG_WINDOW = LONG_WINDOW_CYC
) (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic SUPPLY_OK,
    input wire logic SUPPLY_UV,
    input wire logic SUPPLY_SHORT,
    input wire logic OVER_TEMP,
    input wire logic WAKE,
    input wire logic STRAP_IN,
    input wire logic SPI_VALID,
    input wire logic [1:0] SPI_KIND,
    input wire logic [SPI_W-1:0] SPI_DATA,
    input wire logic WD_TRIGGER,
    input wire logic WD_MISSED,
    input wire logic SECOND_MISS_SELECT,
    input wire logic MAX_RESET_LIMIT,
    output logic RESET_N_OUT,
    output logic MAIN_REG_EN,
    output logic FAIL_OUT,
    output logic STRAP_OE,
    output logic STRAP_PULLUP,
    output logic DEV_MODE,
    output logic WD_RUN,
    output logic WD_FAIL_FLAG,
    output logic UV_FLAG,
    output logic SPI_FAIL,
    output logic [2:0] MODE_FIELD,
    output logic [5:0] MODE_STATE
);
    mode_seq_if tif();
    seq_timer u_seq_timer (
        .clk(CLK),
        .rst_n(RST_N),
        .t(tif)
    );
    // Asynchronous pins pass two flops; only the second stage is read.
    logic [6:0] s1_q, s2_q;
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            s1_q <= 7'h00;
            s2_q <= 7'h00;
        end else begin
            s1_q <= {STRAP_IN, WAKE, OVER_TEMP, SUPPLY_SHORT, SUPPLY_UV, SUPPLY_OK, WD_MISSED};
            s2_q <= s1_q;
        end
    end
    logic miss_s, ok_s, uv_s, short_s, ot_s, wake_s, strap_s;
    assign {strap_s, wake_s, ot_s, short_s, uv_s, ok_s, miss_s} = s2_q;

    mode_e st_q, st_d;
    logic rst_out_q, rst_out_d, fail_q, fail_d, dev_q, dev_d, wdrun_q, wdrun_d;
    logic wdf_q, wdf_d, uv_q, uv_d, spif_q, spif_d, timing_q, timing_d;
    logic [2:0] field_q, field_d;
    logic [1:0] miss_q, miss_d, rstcnt_q, rstcnt_d;
    logic [2:0] req;
    logic wd_event, critical;
    assign req = SPI_DATA[CMD_MODE_POS +: 3]; // RL6
    assign critical = ot_s | short_s; // RL4
    always_comb begin
        st_d = st_q;
        rst_out_d = rst_out_q;
        fail_d = fail_q;
        dev_d = dev_q;
        wdrun_d = wdrun_q;
        wdf_d = wdf_q;
        uv_d = uv_q;
        spif_d = spif_q;
        timing_d = timing_q;
        field_d = field_q;
        miss_d = miss_q;
        rstcnt_d = rstcnt_q;
        tif.start = 1'b0;
        tif.load = 32'(RESET_DELAY); // RL23
        tif.run = timing_q;
        wd_event = 1'b0;
        if (WD_TRIGGER) begin
            miss_d = 2'h0;
            rstcnt_d = 2'h0; // RL24
        end
        // Watchdog misses count only when the watchdog is running and not halted.
        if (miss_s && wdrun_q && !dev_q && (st_q == ST_NORMAL || st_q == ST_STOP)) begin // RL5
            if (SECOND_MISS_SELECT || miss_q != 2'h0) begin // RL10 RL11 RL12
                miss_d = 2'h0;
                if (!MAX_RESET_LIMIT || rstcnt_q < 2'(WD_RESET_LIMIT)) begin // RL17
                    wd_event = 1'b1;
                end
            end else begin
                miss_d = 2'h1;
            end
        end
        case (st_q)
            ST_INIT: begin
                // Wake input is not looked at here, so wakes are dropped.
                if (!ok_s) begin // RL18
                    rst_out_d = 1'b0; // RL20
                    timing_d = 1'b0;
                end else if (!timing_q && !rst_out_q) begin
                    tif.start = 1'b1; // RL14
                    timing_d = 1'b1;
                end
                if (timing_q) begin
                    dev_d = !strap_s; // RL8 RL9
                end
                if (tif.done) begin
                    timing_d = 1'b0;
                    rst_out_d = 1'b1; // RL14
                    wdrun_d = 1'b1;
                    tif.start = 1'b1;
                    tif.load = 32'(LONG_WINDOW);
                end
                if (rst_out_q && !dev_q) begin
                    tif.run = 1'b1;
                    if (tif.done) begin
                        wdf_d = 1'b1; // RL16
                        fail_d = 1'b1;
                        st_d = ST_RESTART;
                        rst_out_d = 1'b0;
                        rstcnt_d = rstcnt_q + 2'h1;
                    end
                end
                if (SPI_VALID && rst_out_q) begin
                    st_d = ST_NORMAL; // RL15 RL9
                end
            end
            ST_NORMAL, ST_STOP: begin
                if (SPI_VALID && SPI_KIND == CMD_MODE) begin
                    field_d = req; // RL7
                    if (req == MODE_SOFT_RESET) begin
                        st_d = ST_INIT; // RL13
                        rst_out_d = 1'b0;
                        wdrun_d = 1'b0;
                    end else if (st_q == ST_STOP && req == MODE_SLEEP) begin
                        spif_d = 1'b1; // RL22
                        st_d = ST_RESTART;
                        rst_out_d = 1'b0;
                    end else if (req == MODE_SLEEP) begin
                        st_d = ST_SLEEP; // RL2
                        rst_out_d = 1'b0;
                    end else if (req == MODE_STOP) begin
                        st_d = ST_STOP;
                    end else begin
                        st_d = ST_NORMAL;
                    end
                end else if (SPI_VALID && SPI_KIND == CMD_OTHER && st_q == ST_STOP) begin
                    spif_d = 1'b1; // RL21
                end
                if (wd_event) begin
                    wdf_d = 1'b1; // RL16
                    fail_d = 1'b1; // RL10
                    st_d = ST_RESTART;
                    rst_out_d = 1'b0;
                    rstcnt_d = rstcnt_q + 2'h1;
                end
                if (uv_s) begin
                    uv_d = 1'b1; // RL3
                    st_d = ST_RESTART;
                    rst_out_d = 1'b0;
                end
            end
            ST_SLEEP: begin
                if (wake_s) begin
                    st_d = ST_RESTART; // RL3
                end
            end
            ST_FAILSAFE: begin
                if (wake_s && !ot_s) begin
                    st_d = ST_RESTART; // RL4
                end
            end
            ST_RESTART: begin
                field_d = MODE_NORMAL; // RL7
                rst_out_d = 1'b0;
                if (!timing_q && ok_s && !uv_s) begin
                    tif.start = 1'b1;
                    timing_d = 1'b1;
                end else if (timing_q && (!ok_s || uv_s)) begin
                    timing_d = 1'b0;
                end
                if (tif.done && timing_q) begin
                    timing_d = 1'b0;
                    rst_out_d = 1'b1; // RL3
                    st_d = ST_NORMAL;
                end
            end
            default: begin
                st_d = ST_INIT;
            end
        endcase
        if (critical && st_q != ST_FAILSAFE && st_q != ST_INIT) begin
            st_d = ST_FAILSAFE; // RL4
            rst_out_d = 1'b0;
            timing_d = 1'b0;
        end
    end
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            st_q <= ST_INIT; // RL1 RL13
            rst_out_q <= 1'b0;
            fail_q <= 1'b0;
            dev_q <= 1'b0;
            wdrun_q <= 1'b0;
            wdf_q <= 1'b0;
            uv_q <= 1'b0;
            spif_q <= 1'b0;
            timing_q <= 1'b0;
            field_q <= MODE_NORMAL;
            miss_q <= 2'h0;
            rstcnt_q <= 2'h0; // RL24
        end else begin
            st_q <= st_d;
            rst_out_q <= rst_out_d;
            fail_q <= fail_d;
            dev_q <= dev_d;
            wdrun_q <= wdrun_d;
            wdf_q <= wdf_d;
            uv_q <= uv_d;
            spif_q <= spif_d;
            timing_q <= timing_d;
            field_q <= field_d;
            miss_q <= miss_d;
            rstcnt_q <= rstcnt_d;
        end
    end
    logic reg_en_q, strap_oe_q, pull_q, wdrun_out_q;
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            reg_en_q <= 1'b0;
            strap_oe_q <= 1'b0;
            pull_q <= 1'b1;
            wdrun_out_q <= 1'b0;
        end else begin
            reg_en_q <= !(st_d == ST_SLEEP || st_d == ST_FAILSAFE); // RL2 RL4
            strap_oe_q <= fail_d && st_d != ST_INIT; // RL8
            pull_q <= st_d == ST_INIT; // RL8
            wdrun_out_q <= wdrun_d && !dev_d; // RL5
        end
    end
    assign RESET_N_OUT = rst_out_q;
    assign MAIN_REG_EN = reg_en_q;
    assign FAIL_OUT = fail_q;
    assign STRAP_OE = strap_oe_q;
    assign STRAP_PULLUP = pull_q;
    assign DEV_MODE = dev_q;
    assign WD_RUN = wdrun_out_q;
    assign WD_FAIL_FLAG = wdf_q;
    assign UV_FLAG = uv_q;
    assign SPI_FAIL = spif_q;
    assign MODE_FIELD = field_q;
    assign MODE_STATE = st_q;

    property p_sleep_reg_off;
        @(posedge CLK) disable iff (!RST_N) (st_q == ST_SLEEP) |-> !MAIN_REG_EN;
    endproperty
    a_sleep_reg_off: assert property (p_sleep_reg_off) else $error("Regulator on in sleep."); // RL2
    property p_restart_clears_field;
        @(posedge CLK) disable iff (!RST_N) (st_q == ST_RESTART) |=> (field_q == MODE_NORMAL);
    endproperty
    a_restart_clears_field: assert property (p_restart_clears_field) else $error("Mode field kept."); // RL7
    property p_init_spi_normal;
        @(posedge CLK) disable iff (!RST_N)
            (st_q == ST_INIT && SPI_VALID && rst_out_q && !critical) |=> (st_q == ST_NORMAL);
    endproperty
    a_init_spi_normal: assert property (p_init_spi_normal) else $error("Init did not leave on SPI."); // RL15
    property p_stop_sleep_fail;
        @(posedge CLK) disable iff (!RST_N)
            (st_q == ST_STOP && SPI_VALID && SPI_KIND == CMD_MODE && req == MODE_SLEEP && !critical)
            |=> (st_q == ST_RESTART && spif_q);
    endproperty
    a_stop_sleep_fail: assert property (p_stop_sleep_fail) else $error("Stop to sleep not refused."); // RL22
    property p_failsafe_stays;
        @(posedge CLK) disable iff (!RST_N) (st_q == ST_FAILSAFE && !wake_s) |=> (st_q == ST_FAILSAFE);
    endproperty
    a_failsafe_stays: assert property (p_failsafe_stays) else $error("Fail-safe left without wake."); // RL4
    property p_reset_low_uv;
        @(posedge CLK) disable iff (!RST_N) (st_q == ST_INIT && !ok_s) |=> !RESET_N_OUT;
    endproperty
    a_reset_low_uv: assert property (p_reset_low_uv) else $error("Reset released below threshold."); // RL20
    property p_dev_no_wd_restart;
        @(posedge CLK) disable iff (!RST_N) (dev_q && st_q == ST_NORMAL && !uv_s && !critical) |=> st_q != ST_RESTART;
    endproperty
    a_dev_no_wd_restart: assert property (p_dev_no_wd_restart) else $error("Watchdog reset in dev mode."); // RL5
    property p_limit;
        @(posedge CLK) disable iff (!RST_N) (MAX_RESET_LIMIT && rstcnt_q == 2'h3) |-> !wd_event;
    endproperty
    a_limit: assert property (p_limit) else $error("Reset beyond limit."); // RL17
    property p_trigger_clears;
        @(posedge CLK) disable iff (!RST_N) (WD_TRIGGER && !wd_event && st_q != ST_INIT) |=> rstcnt_q == 2'h0;
    endproperty
    a_trigger_clears: assert property (p_trigger_clears) else $error("Counter not cleared."); // RL24
endmodule // mode_sequencer

// file: tb/host_model.sv
module host_model
    import mode_seq_pkg::*;
(
    input wire logic CLK,
    input wire logic RESET_N,
    output logic SPI_VALID,
    output logic [1:0] SPI_KIND,
    output logic [SPI_W-1:0] SPI_DATA,
    output logic WD_TRIGGER
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        SPI_VALID = 1'b0;
        SPI_KIND = 2'h0;
        SPI_DATA = 16'h0000;
        WD_TRIGGER = 1'b0;
    end

    // A host held in reset cannot talk, so a word waits for the reset output to be released.
    task automatic send_word(input logic [1:0] kind, input logic [SPI_W-1:0] data);
        int n;
        n = 0;
        while (RESET_N !== 1'b1 && n < 200) begin
            @(negedge CLK);
            n++;
        end
        @(negedge CLK);
        SPI_VALID = 1'b1;
        SPI_KIND = kind;
        SPI_DATA = data;
        @(negedge CLK);
        SPI_VALID = 1'b0;
        // Idle data is inverted so a stale word never passes for a fresh one.
        SPI_DATA = ~data;
    endtask

    task automatic trigger();
        @(negedge CLK);
        WD_TRIGGER = 1'b1;
        @(negedge CLK);
        WD_TRIGGER = 1'b0;
    endtask

    // First a watchdog trigger, then one arbitrary command.
    task automatic start_up(input logic [SPI_W-1:0] data);
        trigger();
        send_word(CMD_ALLOWED, data);
    endtask
endmodule // host_model

// file: tb/supply_chip_mode_sequencer_test.sv
module supply_chip_mode_sequencer_test
    import mode_seq_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int RD = 8;
    localparam int LW = 40;
    logic CLK = 1'b0;
    logic RST_N = 1'b0;
    logic SUPPLY_OK = 1'b0;
    logic SUPPLY_UV = 1'b0;
    logic SUPPLY_SHORT = 1'b0;
    logic OVER_TEMP = 1'b0;
    logic WAKE = 1'b0;
    logic STRAP_IN = 1'b1;
    logic WD_MISSED = 1'b0;
    logic SECOND_MISS_SELECT = 1'b0;
    logic MAX_RESET_LIMIT = 1'b0;
    logic SPI_VALID, WD_TRIGGER, RESET_N_OUT, MAIN_REG_EN, FAIL_OUT, DEV_MODE, WD_RUN, WD_FAIL_FLAG, UV_FLAG, SPI_FAIL;
    logic STRAP_OE, STRAP_PULLUP;
    logic [1:0] SPI_KIND;
    logic [SPI_W-1:0] SPI_DATA;
    logic [2:0] MODE_FIELD;
    logic [5:0] MODE_STATE;
    logic [5:0] last_mode = 6'h01;
    mode_e exp_q[$];
    int error_cnt = 0;
    int tests_run = 0;
    int cycles = 0;
    int n;

    always #4 CLK = ~CLK;

    mode_sequencer #(.RESET_DELAY(RD), .LONG_WINDOW(LW)) u_mode_sequencer (
        .CLK(CLK), .RST_N(RST_N), .SUPPLY_OK(SUPPLY_OK), .SUPPLY_UV(SUPPLY_UV), .SUPPLY_SHORT(SUPPLY_SHORT),
        .OVER_TEMP(OVER_TEMP), .WAKE(WAKE), .STRAP_IN(STRAP_IN), .SPI_VALID(SPI_VALID), .SPI_KIND(SPI_KIND),
        .SPI_DATA(SPI_DATA), .WD_TRIGGER(WD_TRIGGER), .WD_MISSED(WD_MISSED),
        .SECOND_MISS_SELECT(SECOND_MISS_SELECT), .MAX_RESET_LIMIT(MAX_RESET_LIMIT), .RESET_N_OUT(RESET_N_OUT),
        .MAIN_REG_EN(MAIN_REG_EN), .FAIL_OUT(FAIL_OUT), .STRAP_OE(STRAP_OE), .STRAP_PULLUP(STRAP_PULLUP),
        .DEV_MODE(DEV_MODE),
        .WD_RUN(WD_RUN), .WD_FAIL_FLAG(WD_FAIL_FLAG), .UV_FLAG(UV_FLAG), .SPI_FAIL(SPI_FAIL),
        .MODE_FIELD(MODE_FIELD), .MODE_STATE(MODE_STATE));

    host_model u_host_model (.CLK(CLK), .RESET_N(RESET_N_OUT), .SPI_VALID(SPI_VALID), .SPI_KIND(SPI_KIND),
        .SPI_DATA(SPI_DATA), .WD_TRIGGER(WD_TRIGGER));

    task automatic check_mode(input logic [5:0] exp, input logic [5:0] got);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask

    task automatic check_flag(input logic exp, input logic got);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Every change of state must match the oldest noted expectation.
    always @(negedge CLK) begin
        if (RST_N === 1'b1 && MODE_STATE !== last_mode) begin
            if (exp_q.size() == 0) check_mode(6'h3f, MODE_STATE);
            else check_mode(exp_q.pop_front(), MODE_STATE);
        end
        last_mode = MODE_STATE;
    end

    always @(posedge CLK) begin
        cycles++;
        if (cycles == 20000) begin
            error_cnt++;
            give_verdict();
        end
    end

    task automatic wait_q(input int left);
        int k;
        k = 0;
        while (exp_q.size() > left && k < 60) begin
            @(negedge CLK);
            k++;
        end
    endtask

    task automatic settle();
        wait_q(0);
        repeat (6) @(negedge CLK);
        if (exp_q.size() != 0) begin
            check_mode(exp_q[0], MODE_STATE);
            exp_q.delete();
        end
    endtask

    task automatic exp_restart();
        exp_q.push_back(ST_RESTART);
        exp_q.push_back(ST_NORMAL);
    endtask

    task automatic pulse(input int which, input int len);
        @(negedge CLK);
        if (which == 0) WAKE = 1'b1;
        else WD_MISSED = 1'b1;
        repeat (len) @(negedge CLK);
        WAKE = 1'b0;
        WD_MISSED = 1'b0;
    endtask

    task automatic wait_release(output int cnt);
        cnt = 0;
        while (RESET_N_OUT !== 1'b1 && cnt < 60) begin
            @(negedge CLK);
            cnt++;
        end
    endtask

    task automatic mode_word(input logic [2:0] m);
        u_host_model.send_word(CMD_MODE, {13'h0000, m});
    endtask

    initial begin
        void'($urandom(32'h0201875b));
        SUPPLY_UV = 1'b1;
        repeat (4) @(negedge CLK);
        RST_N = 1'b1;
        pulse(0, 3);
        settle();
        check_flag(1'b0, UV_FLAG);
        check_flag(1'b0, FAIL_OUT);
        check_flag(1'b0, RESET_N_OUT);
        check_flag(1'b1, STRAP_PULLUP);
        check_flag(1'b0, STRAP_OE);
        SUPPLY_UV = 1'b0;
        SUPPLY_OK = 1'b1;
        wait_release(n);
        check_flag(1'b1, n >= RD && n <= RD + 6);
        check_flag(1'b1, WD_RUN);
        exp_q.push_back(ST_NORMAL);
        u_host_model.start_up(16'($urandom()));
        settle();
        check_flag(1'b0, STRAP_PULLUP);
        $display("test start_up done");
        exp_q.push_back(ST_STOP);
        mode_word(MODE_STOP);
        settle();
        check_flag(1'b1, MAIN_REG_EN);
        u_host_model.send_word(CMD_ALLOWED, 16'($urandom()));
        settle();
        check_flag(1'b0, SPI_FAIL);
        u_host_model.send_word(CMD_OTHER, 16'($urandom()));
        settle();
        check_flag(1'b1, SPI_FAIL);
        exp_restart();
        mode_word(MODE_SLEEP);
        wait_q(1);
        check_flag(1'b0, RESET_N_OUT);
        // The field is cleared one cycle into restart, so look a cycle later.
        @(negedge CLK);
        check_mode({3'h0, MODE_NORMAL}, {3'h0, MODE_FIELD});
        settle();
        exp_q.push_back(ST_SLEEP);
        mode_word(MODE_SLEEP);
        settle();
        check_flag(1'b0, MAIN_REG_EN);
        exp_restart();
        pulse(0, 3);
        settle();
        exp_restart();
        SUPPLY_UV = 1'b1;
        wait_q(1);
        check_flag(1'b1, UV_FLAG);
        SUPPLY_UV = 1'b0;
        settle();
        $display("test modes done");
        for (int c = 0; c < 2; c++) begin
            SECOND_MISS_SELECT = c[0];
            u_host_model.trigger();
            if (c == 0) begin
                pulse(1, 1);
                settle();
                check_flag(1'b0, FAIL_OUT);
            end
            exp_restart();
            pulse(1, 1);
            wait_q(1);
            check_flag(1'b1, FAIL_OUT);
            check_flag(1'b1, WD_FAIL_FLAG);
            check_flag(1'b1, STRAP_OE);
            settle();
        end
        MAX_RESET_LIMIT = 1'b1;
        u_host_model.trigger();
        for (int k = 0; k < 4; k++) begin
            if (k < WD_RESET_LIMIT) exp_restart();
            pulse(1, 1);
            settle();
        end
        MAX_RESET_LIMIT = 1'b0;
        u_host_model.trigger();
        $display("test watchdog done");
        for (int f = 0; f < 2; f++) begin
            exp_q.push_back(ST_FAILSAFE);
            OVER_TEMP = (f == 0);
            SUPPLY_SHORT = (f == 1);
            settle();
            check_flag(1'b0, MAIN_REG_EN);
            if (f == 0) begin
                pulse(0, 3);
                settle();
            end
            OVER_TEMP = 1'b0;
            SUPPLY_SHORT = 1'b0;
            exp_restart();
            pulse(0, 3);
            settle();
        end
        $display("test fail_safe done");
        STRAP_IN = 1'b0;
        exp_q.push_back(ST_INIT);
        mode_word(MODE_SOFT_RESET);
        wait_q(0);
        check_flag(1'b0, STRAP_OE);
        check_flag(1'b1, STRAP_PULLUP);
        wait_release(n);
        check_flag(1'b1, DEV_MODE);
        exp_q.push_back(ST_NORMAL);
        u_host_model.start_up(16'($urandom()));
        settle();
        check_flag(1'b0, WD_RUN);
        pulse(1, 1);
        settle();
        exp_q.push_back(ST_STOP);
        mode_word(MODE_STOP);
        settle();
        $display("test development done");
        // No command after a soft reset: the long window must run out into restart.
        STRAP_IN = 1'b1;
        exp_q.push_back(ST_INIT);
        exp_restart();
        mode_word(MODE_SOFT_RESET);
        wait_q(1);
        check_flag(1'b0, RESET_N_OUT);
        settle();
        check_flag(1'b0, DEV_MODE);
        $display("test long window done");
        give_verdict();
    end
endmodule // supply_chip_mode_sequencer_test
